// [design/serial_audio_quad_config.sv]
// Audio serial configuration registers, clock generation, framing and sample FIFO
//
// Functional notes
// - Bit 11 picks serial port or audio mode; write ignored while either is enabled.
// - Bit 10 enables audio function; no effect while serial port mode selected.
// - Role field: slave tx, slave rx, master tx, master rx.
// - PCM sync bit picks short or long frame pulse, PCM framing only.
// - Framing field: Philips, MSB-justified, LSB-justified, PCM.
// - Polarity bit sets the idle level of the bit clock.
// - Sample width field: 16, 24, 32 bits, code 3 reserved.
// - Channel bit picks 16 or 32 bits; never shorter than the sample.
// - Prescaler bit 9 enables the master clock pin driver.
// - Divider ratio is twice the factor plus the odd bit.
// - Drive bit forces lines three and four high in single-wire mode.
// - Quad direction bit selects quad write or quad read.
// - Quad enable bit selects single-wire or four-line mode.
// - Quad register exists only in the first instance.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps

// ****************************************
// Sample FIFO
// ****************************************
module audio_sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  output logic out_valid
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic room_ff;
  logic empty_ff;
  logic push;
  logic pop;
  logic [AW:0] nxt_count;

  // Handshakes and occupancy
  assign push = in_valid & room_ff;
  assign pop = out_ready & ~empty_ff;
  assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready = room_ff; // Straight from a flop
  assign out_valid = ~empty_ff;
  assign out_data = mem[rd_ptr_ff];

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      room_ff <= 1'b1;
      empty_ff <= 1'b1;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + AW'(push);
      rd_ptr_ff <= rd_ptr_ff + AW'(pop);
      count_ff <= nxt_count;
      room_ff <= (nxt_count != (AW+1)'(DEPTH));
      empty_ff <= (nxt_count == '0);
    end
  end
endmodule // audio_sample_fifo

// ****************************************
// Top level
// ****************************************
module serial_audio_quad_config #(
  parameter bit FIRST_INSTANCE = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [audio_cfg_pkg::ADDR_W-1:0] paddr,
  input wire logic [audio_cfg_pkg::DATA_W-1:0] pwdata,
  output logic [audio_cfg_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_port_enable,
  input wire logic [audio_cfg_pkg::FIFO_WIDTH-1:0] sample_data,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic ext_bit_clock_in,
  input wire logic ext_word_select_in,
  input wire logic serial_data_in,
  output logic audio_bit_clock,
  output logic audio_bit_clock_oe,
  output logic word_select,
  output logic word_select_oe,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic audio_master_clock,
  output logic audio_master_clock_oe,
  output logic [1:0] upper_lines_out,
  output logic [1:0] upper_lines_oe,
  output logic quad_enable,
  output logic quad_read_select,
  output logic [audio_cfg_pkg::FIFO_WIDTH-1:0] rx_sample,
  output logic rx_valid
);
  import audio_cfg_pkg::*;

  logic [11:0] ctl_ff;
  logic [9:0] psc_ff;
  logic [2:0] qctl_ff;
  logic [DATA_W-1:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [8:0] div_cnt_ff;
  logic mck_ff;
  logic mck_oe_ff;
  logic bck_int_ff;
  logic bck_prev_ff;
  logic bck_oe_ff;
  logic ws_ff;
  logic ws_prev_ff;
  logic sd_ff;
  logic sd_oe_ff;
  logic [5:0] bit_cnt_ff;
  logic [FIFO_WIDTH-1:0] cur_word_ff;
  logic [FIFO_WIDTH-1:0] rx_shift_ff;
  logic [FIFO_WIDTH-1:0] rx_sample_ff;
  logic rx_valid_ff;
  logic [1:0] upper_ff;

  // ****************************************
  // APB decode
  // ****************************************
  logic setup;
  logic hit_ctl;
  logic hit_psc;
  logic hit_q;
  logic hit_any;
  logic wr_acc;
  logic mode_lock;
  logic [11:0] wdata_ctl;
  logic [DATA_W-1:0] rd_mux;

  // Address match and read mux
  assign setup = psel & ~penable;
  assign hit_ctl = (paddr == OFS_AUDIO_CONTROL);
  assign hit_psc = (paddr == OFS_AUDIO_CLOCK_PRESCALER);
  assign hit_q = (paddr == OFS_QUAD_WIRE_CONTROL) & FIRST_INSTANCE;
  assign hit_any = hit_ctl | hit_psc | hit_q;
  assign wr_acc = psel & penable & pready_ff & pwrite & hit_any;
  assign rd_mux = hit_ctl ? {20'h00000, ctl_ff} :
                  hit_psc ? {22'h000000, psc_ff} :
                  hit_q ? {29'h00000000, qctl_ff} : 32'h00000000;
  // Mode bit frozen while either function is on
  assign mode_lock = ctl_ff[CTL_ENABLE] | serial_port_enable;
  assign wdata_ctl = (pwdata[11:0] & CTL_WMASK & ~CTL_MODE_BIT) |
                     ((mode_lock ? ctl_ff : pwdata[11:0]) & CTL_MODE_BIT);

  // Zero-wait answer registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~hit_any;
      prdata_ff <= (setup & ~pwrite) ? rd_mux : '0;
    end
  end

  // Register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff <= CTL_RESET;
      psc_ff <= PSC_RESET;
      qctl_ff <= QCTL_RESET;
    end else if (wr_acc) begin
      if (hit_ctl) begin
        ctl_ff <= wdata_ctl;
      end
      if (hit_psc) begin
        psc_ff <= pwdata[9:0];
      end
      if (hit_q) begin
        qctl_ff <= pwdata[2:0];
      end
    end
  end

  // ****************************************
  // Field decode
  // ****************************************
  logic active;
  logic master;
  logic tx_role;
  role_t role;
  std_t std;
  width_t width;
  logic pcm_long;
  logic idle_lvl;
  logic chan32;
  logic [5:0] chan_bits;
  logic [5:0] samp_bits;
  logic [5:0] frame_last;
  logic [5:0] lsb_off;
  logic [8:0] ratio;

  // Settings used by the engine
  assign active = ctl_ff[CTL_MODE_SEL] & ctl_ff[CTL_ENABLE];
  assign role = role_t'(ctl_ff[CTL_ROLE_LSB +: 2]);
  assign master = (role == ROLE_MASTER_TX) | (role == ROLE_MASTER_RX);
  assign tx_role = (role == ROLE_SLAVE_TX) | (role == ROLE_MASTER_TX);
  assign std = std_t'(ctl_ff[CTL_STD_LSB +: 2]);
  assign pcm_long = ctl_ff[CTL_PCM_LONG];
  assign idle_lvl = ctl_ff[CTL_IDLE_LVL];
  assign width = width_t'(ctl_ff[CTL_WIDTH_LSB +: 2]);
  assign samp_bits = (width == WID_16) ? BITS_16 : (width == WID_24) ? BITS_24 : BITS_32;
  assign chan32 = ctl_ff[CTL_CHAN] | (width != WID_16);
  assign chan_bits = chan32 ? BITS_32 : BITS_16;
  assign frame_last = chan32 ? FRAME_LAST_32 : FRAME_LAST_16;
  assign lsb_off = (std == STD_LSB) ? (chan_bits - samp_bits) : 6'h00;
  assign ratio = {psc_ff[PSC_DIV_LSB +: 8], 1'b0} + {8'h00, psc_ff[PSC_ODD]};

  // ****************************************
  // Clock generation
  // ****************************************
  logic wrap;
  logic bck_now;
  logic bck_edge;
  logic shift_edge;
  logic sample_edge;

  // Divider wraps every ratio cycles
  assign wrap = active & master & (div_cnt_ff == ratio - 9'h001);
  assign bck_now = master ? bck_int_ff : ext_bit_clock_in;
  assign bck_edge = active & (bck_now ^ bck_prev_ff);
  assign shift_edge = bck_edge & (bck_now == idle_lvl);
  assign sample_edge = bck_edge & (bck_now != idle_lvl);

  // Divider, master clock and bit clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_ff <= 9'h000;
      mck_ff <= 1'b0;
      mck_oe_ff <= 1'b0;
      bck_int_ff <= 1'b0;
      bck_prev_ff <= 1'b0;
      bck_oe_ff <= 1'b0;
    end else begin
      div_cnt_ff <= (!active | !master | wrap) ? 9'h000 : div_cnt_ff + 9'h001;
      mck_ff <= active & master & (div_cnt_ff < {1'b0, psc_ff[PSC_DIV_LSB +: 8]});
      mck_oe_ff <= active & psc_ff[PSC_MCK_OE];
      bck_int_ff <= (!active | !master) ? idle_lvl : (wrap ? ~bck_int_ff : bck_int_ff);
      bck_prev_ff <= bck_now;
      bck_oe_ff <= active & master;
    end
  end

  // ****************************************
  // Framing
  // ****************************************
  logic slv_ws_chg;
  logic [5:0] nxt_bit_cnt;
  logic [5:0] ahead;
  logic [5:0] nxt_pos;
  logic [5:0] cur_pos;
  logic [5:0] dpos;
  logic [5:0] dpos_rx;
  logic [5:0] bit_idx;
  logic new_chan;
  logic pop;
  logic fifo_valid;
  logic [FIFO_WIDTH-1:0] fifo_data;
  logic [FIFO_WIDTH-1:0] word_now;
  logic nxt_ws;
  logic nxt_sd;
  logic rx_take;
  logic rx_end;
  logic [FIFO_WIDTH-1:0] nxt_rx_shift;

  // Slave follows the partner's word select, except in PCM framing
  assign slv_ws_chg = !master & (ext_word_select_in != ws_prev_ff) & (std != STD_PCM);
  assign nxt_bit_cnt = slv_ws_chg ? (ext_word_select_in ? chan_bits : 6'h00) :
                       (bit_cnt_ff == frame_last) ? 6'h00 : bit_cnt_ff + 6'h01;
  assign nxt_pos = chan32 ? {1'b0, nxt_bit_cnt[4:0]} : {2'h0, nxt_bit_cnt[3:0]};
  assign cur_pos = chan32 ? {1'b0, bit_cnt_ff[4:0]} : {2'h0, bit_cnt_ff[3:0]};
  // Philips moves word select one bit ahead of the MSB
  assign ahead = (std == STD_PHILIPS) ? nxt_bit_cnt + 6'h01 : nxt_bit_cnt;
  assign nxt_ws = (std == STD_PCM) ?
                  (pcm_long ? (nxt_bit_cnt < PCM_LONG_BITS) : (nxt_bit_cnt == 6'h00)) :
                  (chan32 ? ahead[5] : ahead[4]);
  // Data bit for the coming slot
  assign new_chan = shift_edge & (nxt_pos == 6'h00);
  assign pop = new_chan & tx_role;
  assign word_now = new_chan ? (fifo_valid ? fifo_data : '0) : cur_word_ff;
  assign dpos = nxt_pos - lsb_off;
  assign bit_idx = samp_bits - 6'h01 - dpos;
  assign nxt_sd = (dpos < samp_bits) & word_now[bit_idx[4:0]];
  // Receive capture
  assign dpos_rx = cur_pos - lsb_off;
  assign rx_take = sample_edge & !tx_role;
  assign rx_end = rx_take & (cur_pos == chan_bits - 6'h01);
  assign nxt_rx_shift = (dpos_rx < samp_bits) ? {rx_shift_ff[FIFO_WIDTH-2:0], serial_data_in} :
                        rx_shift_ff;

  // Bit counter, word select and data out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_ff <= FRAME_LAST_32;
      ws_ff <= 1'b0;
      ws_prev_ff <= 1'b0;
      sd_ff <= 1'b0;
      sd_oe_ff <= 1'b0;
      cur_word_ff <= '0;
    end else if (!active) begin
      bit_cnt_ff <= frame_last;
      ws_ff <= 1'b0;
      ws_prev_ff <= ext_word_select_in;
      sd_ff <= 1'b0;
      sd_oe_ff <= 1'b0;
      cur_word_ff <= '0;
    end else begin
      sd_oe_ff <= tx_role;
      if (shift_edge) begin
        bit_cnt_ff <= nxt_bit_cnt;
        ws_ff <= master & nxt_ws;
        ws_prev_ff <= ext_word_select_in;
        sd_ff <= tx_role & nxt_sd;
        cur_word_ff <= word_now;
      end
    end
  end

  // Receive word assembly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_shift_ff <= '0;
      rx_sample_ff <= '0;
      rx_valid_ff <= 1'b0;
    end else begin
      rx_valid_ff <= rx_end;
      if (rx_end) begin
        rx_sample_ff <= nxt_rx_shift;
        rx_shift_ff <= '0;
      end else if (rx_take) begin
        rx_shift_ff <= nxt_rx_shift;
      end
    end
  end

  // Quad line drivers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_ff <= 2'h0;
    end else begin
      upper_ff <= {2{FIRST_INSTANCE & qctl_ff[Q_DRIVE] & ~qctl_ff[Q_EN]}};
    end
  end

  // ****************************************
  // FIFO instance
  // ****************************************
  audio_sample_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_data(sample_data),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .out_data(fifo_data),
    .out_ready(pop),
    .out_valid(fifo_valid)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign audio_bit_clock = bck_int_ff;
  assign audio_bit_clock_oe = bck_oe_ff;
  assign word_select = ws_ff;
  assign word_select_oe = bck_oe_ff;
  assign serial_data_out = sd_ff;
  assign serial_data_oe = sd_oe_ff;
  assign audio_master_clock = mck_ff;
  assign audio_master_clock_oe = mck_oe_ff;
  assign upper_lines_out = upper_ff;
  assign upper_lines_oe = upper_ff;
  assign quad_enable = qctl_ff[Q_EN];
  assign quad_read_select = qctl_ff[Q_READ];
  assign rx_sample = rx_sample_ff;
  assign rx_valid = rx_valid_ff;

  // ****************************************
  // Assertions
  // ****************************************
  property p_mode_lock;
    @(posedge pclk) disable iff (!presetn)
    (wr_acc & hit_ctl & mode_lock) |=> (ctl_ff[CTL_MODE_SEL] == $past(ctl_ff[CTL_MODE_SEL]));
  endproperty
  a_mode_lock: assert property (p_mode_lock) else $error("mode bit changed while locked");

  property p_disabled_quiet;
    @(posedge pclk) disable iff (!presetn)
    !active |=> (!word_select_oe && !serial_data_oe && !audio_bit_clock_oe);
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("pins driven while off");

  property p_role_drive;
    @(posedge pclk) disable iff (!presetn)
    active |=> (serial_data_oe == !$past(ctl_ff[CTL_ROLE_LSB]));
  endproperty
  a_role_drive: assert property (p_role_drive) else $error("data driver wrong for role");

  property p_pcm_short;
    @(posedge pclk) disable iff (!presetn)
    (shift_edge & master & (std == STD_PCM) & !pcm_long & (nxt_bit_cnt != 6'h00))
      |=> !word_select;
  endproperty
  a_pcm_short: assert property (p_pcm_short) else $error("short sync too long");

  property p_idle_level;
    @(posedge pclk) disable iff (!presetn)
    (!active ##1 !active) |-> (audio_bit_clock == $past(idle_lvl));
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("bit clock not at idle level");

  property p_chan_width;
    @(posedge pclk) disable iff (!presetn)
    (width != WID_16) |-> (chan_bits == BITS_32);
  endproperty
  a_chan_width: assert property (p_chan_width) else $error("channel shorter than sample");

  property p_mck_oe;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> (audio_master_clock_oe == ($past(active) & $past(psc_ff[PSC_MCK_OE])));
  endproperty
  a_mck_oe: assert property (p_mck_oe) else $error("master clock enable wrong");

  property p_div_ratio;
    @(posedge pclk) disable iff (!presetn)
    (wrap & (ratio == 9'h005)) |=> (!wrap [*4]) ##1 (wrap | !active | !master);
  endproperty
  a_div_ratio: assert property (p_div_ratio) else $error("divider period wrong");

  property p_upper_drive;
    @(posedge pclk) disable iff (!presetn)
    (qctl_ff[Q_DRIVE] & !qctl_ff[Q_EN] & FIRST_INSTANCE) |=> (upper_lines_oe == 2'h3);
  endproperty
  a_upper_drive: assert property (p_upper_drive) else $error("upper lines not driven");

  property p_no_quad;
    @(posedge pclk) disable iff (!presetn)
    !FIRST_INSTANCE |-> (!quad_enable && !quad_read_select && upper_lines_oe == 2'h0);
  endproperty
  a_no_quad: assert property (p_no_quad) else $error("quad active in other instance");

  property p_slave_clock;
    @(posedge pclk) disable iff (!presetn)
    (active & !master) |=> !audio_bit_clock_oe;
  endproperty
  a_slave_clock: assert property (p_slave_clock) else $error("slave drives bit clock");
endmodule // serial_audio_quad_config

// [pkg/audio_cfg_pkg.sv]
// Register map, field layout and framing constants of the audio serial configuration block
package audio_cfg_pkg;
  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_AUDIO_CONTROL = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_AUDIO_CLOCK_PRESCALER = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_QUAD_WIRE_CONTROL = 8'h80;

  // ****************************************
  // Reset values and writable masks
  // ****************************************
  localparam logic [11:0] CTL_RESET = 12'h000;
  localparam logic [11:0] CTL_WMASK = 12'hFBF;
  localparam logic [11:0] CTL_MODE_BIT = 12'h800;
  localparam logic [9:0] PSC_RESET = 10'h002;
  localparam logic [2:0] QCTL_RESET = 3'h0;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTL_MODE_SEL = 11;
  localparam int CTL_ENABLE = 10;
  localparam int CTL_ROLE_LSB = 8;
  localparam int CTL_PCM_LONG = 7;
  localparam int CTL_STD_LSB = 4;
  localparam int CTL_IDLE_LVL = 3;
  localparam int CTL_WIDTH_LSB = 1;
  localparam int CTL_CHAN = 0;
  localparam int PSC_MCK_OE = 9;
  localparam int PSC_ODD = 8;
  localparam int PSC_DIV_LSB = 0;
  localparam int Q_DRIVE = 2;
  localparam int Q_READ = 1;
  localparam int Q_EN = 0;

  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic [1:0] {
    ROLE_SLAVE_TX = 2'h0,
    ROLE_SLAVE_RX = 2'h1,
    ROLE_MASTER_TX = 2'h2,
    ROLE_MASTER_RX = 2'h3
  } role_t;
  typedef enum logic [1:0] {
    STD_PHILIPS = 2'h0,
    STD_MSB = 2'h1,
    STD_LSB = 2'h2,
    STD_PCM = 2'h3
  } std_t;
  typedef enum logic [1:0] {
    WID_16 = 2'h0,
    WID_24 = 2'h1,
    WID_32 = 2'h2,
    WID_RSVD = 2'h3
  } width_t;

  // ****************************************
  // Bit counts
  // ****************************************
  localparam logic [5:0] BITS_16 = 6'h10;
  localparam logic [5:0] BITS_24 = 6'h18;
  localparam logic [5:0] BITS_32 = 6'h20;
  localparam logic [5:0] FRAME_LAST_16 = 6'h1F;
  localparam logic [5:0] FRAME_LAST_32 = 6'h3F;
  localparam logic [5:0] PCM_LONG_BITS = 6'h0D;
  localparam int FIFO_WIDTH = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
endpackage

// [verification/codec_model.sv]
// Codec-side model: clock source for slave roles, word capture for master transmit
`timescale 1ns/1ps
module codec_model (
  input wire logic pclk,
  input wire logic slave_run,
  input wire logic audio_bit_clock,
  input wire logic word_select,
  input wire logic serial_data_out,
  output logic ext_bit_clock_in,
  output logic ext_word_select_in,
  output logic serial_data_in,
  output logic [15:0] last_word
);
  logic [15:0] shift;
  logic [4:0] nbits;
  logic ws_seen;
  logic [7:0] ph;
  initial begin
    ext_bit_clock_in = 1'b0;
    ext_word_select_in = 1'b0;
    serial_data_in = 1'b0;
    last_word = 16'h0000;
    shift = 16'h0000;
    nbits = 5'h00;
    ws_seen = 1'b0;
    ph = 8'h00;
  end
  // ****************************************
  // Clock source for slave roles
  // ****************************************
  // Clock stands still between runs, data line keeps flipping so stale bits show
  always @(posedge pclk) begin
    if (slave_run) begin
      ph <= ph + 8'h01;
      if (ph[1:0] == 2'h3) ext_bit_clock_in <= ~ext_bit_clock_in;
      if (ph[6:0] == 7'h7F) ext_word_select_in <= ~ext_word_select_in;
      if (ph[2:0] == 3'h7) serial_data_in <= ph[5];
    end else begin
      ext_bit_clock_in <= 1'b0;
      serial_data_in <= ~serial_data_in;
    end
  end
  // ****************************************
  // Capture of one 16-bit channel per word select phase
  // ****************************************
  // Leading edge with idle-low clock; a word counts only if the slot was whole
  always @(posedge audio_bit_clock) begin
    ws_seen <= word_select;
    if (word_select != ws_seen) begin
      if (nbits == 5'h10) last_word <= shift;
      nbits <= 5'h01;
      shift <= {15'h0000, serial_data_out};
    end else begin
      nbits <= nbits + 5'h01;
      shift <= {shift[14:0], serial_data_out};
    end
  end
endmodule // codec_model

// [verification/testbench.sv]
// Register, link and buffer tests of the audio serial configuration block
`timescale 1ns/1ps
module testbench;
  import audio_cfg_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, sample_data = 32'hC3C3C3C3, rx_sample, r;
  logic pready, pslverr, serial_port_enable = 1'b0, sample_valid = 1'b0, sample_ready;
  logic ext_bit_clock_in, ext_word_select_in, serial_data_in, audio_bit_clock;
  logic audio_bit_clock_oe, word_select, word_select_oe, serial_data_out, serial_data_oe;
  logic audio_master_clock, audio_master_clock_oe, quad_enable, quad_read_select, rx_valid;
  logic [1:0] upper_lines_out, upper_lines_oe;
  logic [15:0] last_word;
  logic slave_run = 1'b0, e, t0;
  int fail_count = 0, num_checks = 0, n;
  serial_audio_quad_config i_serial_audio_quad_config (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .serial_port_enable, .sample_data,
    .sample_valid, .sample_ready, .ext_bit_clock_in, .ext_word_select_in, .serial_data_in,
    .audio_bit_clock, .audio_bit_clock_oe, .word_select, .word_select_oe, .serial_data_out,
    .serial_data_oe, .audio_master_clock, .audio_master_clock_oe, .upper_lines_out,
    .upper_lines_oe, .quad_enable, .quad_read_select, .rx_sample, .rx_valid);
  codec_model i_codec_model (.pclk, .slave_run, .audio_bit_clock, .word_select,
    .serial_data_out, .ext_bit_clock_in, .ext_word_select_in, .serial_data_in, .last_word);
  always #5 pclk = ~pclk;
  // ****************************************
  // Compare, verdict and bus tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One APB transfer; waits on pready without a bound of its own
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    repeat (2) @(posedge pclk);
  endtask
  task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(r, exp);
    check(e, 1'b0);
  endtask
  initial begin
    #500000;
    fail_count++;
    tally_and_finish();
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    read_check(OFS_AUDIO_CONTROL, 32'h0);
    read_check(OFS_AUDIO_CLOCK_PRESCALER, 32'h2);
    read_check(OFS_QUAD_WIRE_CONTROL, 32'h0);
    xfer(1'b0, 8'h40, 32'h0);
    check({r[30:0], e}, 32'h1);
    // Every role and standard, width codes 0 to 2, channel widened where needed
    for (int i = 0; i < 4; i++) begin
      n = 32'h800 | (i << 8) | (i[0] << 7) | (i << 4) | (i[0] << 3) | ((i % 3) << 1);
      n = n | ((i % 3) != 0);
      wr(OFS_AUDIO_CONTROL, n);
      read_check(OFS_AUDIO_CONTROL, n);
    end
    wr(OFS_AUDIO_CONTROL, 32'hFFFFFBFF);
    read_check(OFS_AUDIO_CONTROL, 32'hBBF);
    wr(OFS_AUDIO_CONTROL, 32'hC00);
    wr(OFS_AUDIO_CONTROL, 32'h0);
    read_check(OFS_AUDIO_CONTROL, 32'h800);
    wr(OFS_AUDIO_CONTROL, 32'h0);
    serial_port_enable <= 1'b1;
    wr(OFS_AUDIO_CONTROL, 32'h800);
    read_check(OFS_AUDIO_CONTROL, 32'h0);
    wr(OFS_AUDIO_CONTROL, 32'h600);
    check(audio_bit_clock_oe, 1'b0);
    wr(OFS_AUDIO_CONTROL, 32'h0);
    serial_port_enable <= 1'b0;
    wr(OFS_AUDIO_CONTROL, 32'h808);
    check(audio_bit_clock, 1'b1);
    wr(OFS_AUDIO_CLOCK_PRESCALER, 32'hFFFFFFFF);
    read_check(OFS_AUDIO_CLOCK_PRESCALER, 32'h3FF);
    // Fill the buffer while nothing drains it
    sample_valid <= 1'b1;
    n = 0;
    repeat (20) begin
      @(posedge pclk);
      if (sample_ready === 1'b1) n++;
    end
    sample_valid <= 1'b0;
    check(n, 16);
    check(sample_ready, 1'b0);
    // Master transmit, MSB-justified, ratio 2*2+1
    wr(OFS_AUDIO_CLOCK_PRESCALER, 32'h302);
    wr(OFS_AUDIO_CONTROL, 32'hA10);
    wr(OFS_AUDIO_CONTROL, 32'hE10);
    check({audio_master_clock_oe, audio_bit_clock_oe, word_select_oe}, 3'h7);
    check(serial_data_oe, 1'b1);
    for (int j = 0; j < 2; j++) begin
      t0 = audio_bit_clock;
      for (n = 0; n < 100 && audio_bit_clock === t0; n++) @(posedge pclk);
    end
    check(n, 5);
    for (n = 0; n < 3000 && last_word !== 16'hC3C3; n++) @(posedge pclk);
    check(last_word, 16'hC3C3);
    for (n = 0; n < 6000 && last_word !== 16'h0; n++) @(posedge pclk);
    check({last_word, sample_ready}, 17'h1);
    wr(OFS_AUDIO_CONTROL, 32'hA10);
    // Slave receive takes its clocks from the codec
    wr(OFS_AUDIO_CONTROL, 32'h910);
    wr(OFS_AUDIO_CONTROL, 32'hD10);
    slave_run <= 1'b1;
    for (n = 0; n < 2000 && rx_valid !== 1'b1; n++) @(posedge pclk);
    check({rx_valid, audio_bit_clock_oe, serial_data_oe}, 3'h4);
    // Whole slots after the first word select change carry 8787
    repeat (300) @(posedge pclk);
    for (n = 0; n < 300 && rx_valid !== 1'b1; n++) @(posedge pclk);
    check(rx_sample, 32'h8787);
    slave_run <= 1'b0;
    wr(OFS_AUDIO_CONTROL, 32'h910);
    // Master receive, PCM short sync: pulse lasts one bit period
    wr(OFS_AUDIO_CONTROL, 32'hB30);
    wr(OFS_AUDIO_CONTROL, 32'hF30);
    for (n = 0; n < 1000 && word_select !== 1'b1; n++) @(posedge pclk);
    for (n = 0; n < 100 && word_select === 1'b1; n++) @(posedge pclk);
    check(n, 10);
    wr(OFS_AUDIO_CONTROL, 32'hB30);
    wr(OFS_QUAD_WIRE_CONTROL, 32'h4);
    check({upper_lines_oe, upper_lines_out}, 4'hF);
    wr(OFS_QUAD_WIRE_CONTROL, 32'h5);
    check({quad_enable, upper_lines_oe}, 3'h4);
    wr(OFS_QUAD_WIRE_CONTROL, 32'hFFFFFFFB);
    check({quad_enable, quad_read_select}, 2'h3);
    read_check(OFS_QUAD_WIRE_CONTROL, 32'h3);
    tally_and_finish();
  end
endmodule // testbench
